// ==== core/fpm_pkg.sv ====
/*
  constants, types and helper functions of the front panel menu control.
  assumes a single 100 MHz clock and a synchronous reset.
*/
package fpm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1_000_000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int TEST_MS = 3000;
  localparam int DEB_MS = 20;
  localparam int LONG_MS = 2000;
  localparam int HOLD_MS = 2000;
  localparam int FAST_MS = 50;
  localparam int ALT_MS = 1000;
  localparam int REV_MS = 3000;

  // ----------------------------------------------------------------
  // keys, bus, stored parameters
  // ----------------------------------------------------------------
  localparam int NKEY = 4;
  localparam int KEY_UP = 0;
  localparam int KEY_DN = 1;
  localparam int KEY_SEL = 2;
  localparam int KEY_ENT = 3;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int PW = 16;
  localparam int PAW = 3;
  localparam int NPAR = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_DISPLAY = 4'h8;
  localparam logic [ADDR_W-1:0] REG_SETUP = 4'hC;
  localparam int CTRL_KEYS_OFF = 0;
  localparam int CTRL_CLR_ALARM = 1;
  localparam logic [PAW-1:0] P_SIG = 3'h0;
  localparam logic [PAW-1:0] P_TYPE = 3'h1;
  localparam logic [PAW-1:0] P_UNIT = 3'h2;
  localparam logic [PAW-1:0] P_AEN = 3'h3;
  localparam logic [PAW-1:0] P_AHI = 3'h4;
  localparam logic [PAW-1:0] P_ALO = 3'h5;
  localparam logic [PAW-1:0] P_ADB = 3'h6;
  localparam logic [PAW-1:0] P_LATCH = 3'h7;
  // signature value is arbitrary
  localparam logic [PW-1:0] SIG = 16'hA55A;
  localparam logic [PW-1:0] TYPE_NONE = 16'h0000;
  localparam logic [PW-1:0] TYPE_SI_DIODE = 16'h0001;
  localparam logic [PW-1:0] DIODE_TYPE_HIGH_RANGE = 16'h0002;
  localparam logic [PW-1:0] RTD_TYPE_250_OHM = 16'h0003;
  localparam logic [PW-1:0] RTD_TYPE_500_OHM = 16'h0004;
  localparam logic [PW-1:0] RTD_TYPE_5000_OHM = 16'h0005;
  localparam logic [PW-1:0] TYPE_NTC = 16'h0006;
  localparam logic [PW-1:0] UNIT_MAX = 16'h0003;
  localparam logic [PW-1:0] SP_MAX = 16'h270F;
  localparam logic [PW-1:0] DB_MAX = 16'h03E7;
  localparam logic [PW-1:0] BOOL_MAX = 16'h0001;
  localparam logic [PW-1:0] ZERO = 16'h0000;
  // unit 0 kelvin, 1 celsius, 2 fahrenheit, 3 sensor units
  localparam logic [NPAR-1:0][PW-1:0] DEFAULTS = {16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, TYPE_NONE, SIG};
  // revision date code is arbitrary
  localparam logic [PW-1:0] REV_DATE = 16'h0101;

  // ----------------------------------------------------------------
  // display codes and states
  // ----------------------------------------------------------------
  localparam logic [3:0] DC_TEST = 4'h0;
  localparam logic [3:0] DC_READING = 4'h1;
  localparam logic [3:0] DC_STATUS = 4'h2;
  localparam logic [3:0] DC_ALARM_HI = 4'h3;
  localparam logic [3:0] DC_ALARM_LO = 4'h4;
  localparam logic [3:0] DC_MENU = 4'h5;
  localparam logic [3:0] DC_PARAM = 4'h6;
  localparam logic [3:0] DC_REV = 4'h7;
  localparam logic [3:0] LED_ALL = 4'hF;
  localparam logic [1:0] ALT_READ = 2'h0;
  localparam logic [1:0] ALT_HI = 2'h1;
  localparam logic [1:0] ALT_LO = 2'h2;

  typedef enum logic [2:0] {
    ST_LOAD_A = 3'h0, ST_LOAD_D = 3'h1, ST_FILL = 3'h3, ST_TEST = 3'h2,
    ST_NORMAL = 3'h6, ST_MENU = 3'h7, ST_EDIT = 3'h5, ST_REV = 3'h4
  } fpm_state_type;

  function automatic logic fpm_numeric(input logic [PAW-1:0] i);
    return (i == P_AHI) || (i == P_ALO) || (i == P_ADB);
  endfunction

  function automatic logic [PW-1:0] fpm_max(input logic [PAW-1:0] i);
    if (i == P_TYPE) return TYPE_NTC;
    else if (i == P_UNIT) return UNIT_MAX;
    else if (i == P_ADB) return DB_MAX;
    else if (fpm_numeric(i)) return SP_MAX;
    else return BOOL_MAX;
  endfunction

  function automatic logic [PW-1:0] fpm_min(input logic [PAW-1:0] i);
    return (i == P_TYPE) ? TYPE_SI_DIODE : ZERO;
  endfunction

endpackage

// ==== core/fpm_param_store.sv ====
/*
  setup parameter store with registered read data.
  contents have no reset, so they survive a reset like a retained store.
*/
`timescale 1ns/1ps
module fpm_param_store #(
  parameter int AW = 3,
  parameter int DW = 16
) (
  input wire logic clock,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rd_r;

  // one port: write or registered read
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rd_r <= mem[addr];
  end

  assign rdata = rd_r;
endmodule // fpm_param_store

// ==== core/fpm_panel.sv ====
/*
  front panel control: key debounce, menu state machine, display select,
  unit LEDs, alarm message alternation, Avalon-MM register slave.
  assumes alarm inputs come from logic on the same clock, keys from pins.
*/
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module fpm_panel #(
  parameter int CYC_MS = fpm_pkg::CYC_PER_MS
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [fpm_pkg::NKEY-1:0] key_n,
  input wire logic alarm_hi_in,
  input wire logic alarm_lo_in,
  input wire logic [fpm_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [fpm_pkg::DATA_W-1:0] writedata,
  output logic [fpm_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic [3:0] disp_code,
  output logic [fpm_pkg::PAW-1:0] disp_item,
  output logic [fpm_pkg::PW-1:0] disp_value,
  output logic [3:0] unit_led,
  output logic keypad_locked,
  output logic hi_latched,
  output logic lo_latched
);
  import fpm_pkg::*;

  typedef struct packed {
    fpm_state_type st;
    logic [PAW-1:0] idx;
    logic menu;
    logic [NPAR-1:0][PW-1:0] cfg;
    logic [PW-1:0] pend;
    logic touched;
    logic [16:0] div;
    logic [11:0] tmr;
    logic [1:0] alt;
    logic [NKEY-1:0] s1;
    logic [NKEY-1:0] s2;
    logic [NKEY-1:0] stable;
    logic [4:0] deb;
    logic [11:0] hold;
    logic [5:0] rep;
    logic long_done;
    logic locked;
    logic hi_lat;
    logic lo_lat;
    logic sw_dis;
    logic [3:0] dcode;
    logic [PAW-1:0] ditem;
    logic [PW-1:0] dval;
    logic [3:0] led;
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    logic mem_we;
    logic [PAW-1:0] mem_a;
    logic [PW-1:0] mem_wd;
  } fpm_panel_type;

  fpm_panel_type q_r, q_nxt;
  logic [PW-1:0] mem_rd;
  logic tick, rep_fire, long_fire, kact, unl;
  logic ev_up, ev_dn, ev_sel, ev_sel_long, ev_ent, ev_ent_long, sw_clr;
  logic [NKEY-1:0] stab, press, rel;
  logic a_hi, a_lo;

  // ----------------------------------------------------------------
  // retained parameter store
  // ----------------------------------------------------------------
  fpm_param_store #(.AW(PAW), .DW(PW)) u_store (
    .clock(clock),
    .we(q_r.mem_we),
    .addr(q_r.mem_a),
    .wdata(q_r.mem_wd),
    .rdata(mem_rd)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.mem_we = 1'b0;
    // key pins through two flops
    q_nxt.s1 = ~key_n;
    q_nxt.s2 = q_r.s1;
    // 1 ms enable pulse
    tick = (q_r.div == 17'(CYC_MS - 1));
    q_nxt.div = tick ? 17'h0_0000 : q_r.div + 17'h0_0001;
    if (tick) begin
      q_nxt.tmr = q_r.tmr + 12'h001;
    end
    stab = q_r.stable;
    if (q_r.s2 == q_r.stable) begin
      q_nxt.deb = 5'h00;
    end else if (tick) begin
      if (q_r.deb == 5'(DEB_MS - 1)) begin
        stab = q_r.s2;
        q_nxt.deb = 5'h00;
      end else begin
        q_nxt.deb = q_r.deb + 5'h01;
      end
    end
    q_nxt.stable = stab;
    press = stab & ~q_r.stable;
    rel = ~stab & q_r.stable;
    rep_fire = 1'b0;
    long_fire = 1'b0;
    if ((press | rel) != '0) begin
      q_nxt.hold = 12'h000;
      q_nxt.rep = 6'h00;
    end else if (tick && stab != '0) begin
      q_nxt.hold = (q_r.hold == 12'hFFF) ? q_r.hold : q_r.hold + 12'h001;
      long_fire = (q_r.hold == 12'(LONG_MS - 1));
      // faster repeat after a long hold
      if (q_r.hold >= 12'(HOLD_MS)) begin
        rep_fire = (q_r.rep == 6'h00);
        q_nxt.rep = (q_r.rep == 6'(FAST_MS - 1)) ? 6'h00 : q_r.rep + 6'h01;
      end
    end
    if (long_fire) begin
      q_nxt.long_done = 1'b1;
    end
    if (press != '0) begin
      q_nxt.long_done = 1'b0;
    end
    kact = ~q_r.sw_dis;
    unl = kact & ~q_r.locked;
    ev_up = unl & (press[KEY_UP] | (rep_fire & stab[KEY_UP] & fpm_numeric(q_r.idx)));
    ev_dn = unl & (press[KEY_DN] | (rep_fire & stab[KEY_DN] & fpm_numeric(q_r.idx)));
    ev_sel = unl & rel[KEY_SEL] & ~q_r.long_done;
    ev_sel_long = unl & long_fire & stab[KEY_SEL];
    ev_ent = unl & rel[KEY_ENT] & ~q_r.long_done;
    ev_ent_long = kact & long_fire & stab[KEY_ENT];
    if (ev_ent_long) begin
      q_nxt.locked = ~q_r.locked;
    end

    // main sequence
    case (q_r.st)
      ST_LOAD_A: begin
        q_nxt.st = ST_LOAD_D;
      end
      ST_LOAD_D: begin
        q_nxt.cfg[q_r.idx] = mem_rd;
        if (q_r.idx == P_LATCH) begin
          q_nxt.idx = P_SIG;
          q_nxt.tmr = 12'h000;
          // a blank or unknown store falls through to the fill
          if (q_r.cfg[P_SIG] == SIG) begin
            q_nxt.st = ST_TEST;
          end else begin
            q_nxt.st = ST_FILL;
          end
        end else begin
          q_nxt.idx = q_r.idx + 3'h1;
          q_nxt.mem_a = q_r.idx + 3'h1;
          q_nxt.st = ST_LOAD_A;
        end
      end
      ST_FILL: begin
        // factory defaults on a blank store
        q_nxt.cfg[q_r.idx] = DEFAULTS[q_r.idx];
        q_nxt.mem_we = 1'b1;
        q_nxt.mem_a = q_r.idx;
        q_nxt.mem_wd = DEFAULTS[q_r.idx];
        q_nxt.idx = q_r.idx + 3'h1;
        q_nxt.tmr = 12'h000;
        if (q_r.idx == P_LATCH) begin
          q_nxt.st = ST_TEST;
        end
      end
      ST_TEST: begin
        if (tick && q_r.tmr == 12'(TEST_MS - 1)) begin
          q_nxt.st = ST_NORMAL;
          q_nxt.tmr = 12'h000;
          q_nxt.alt = ALT_READ;
        end
      end
      ST_NORMAL: begin
        if (ev_sel_long) begin
          q_nxt.st = ST_REV;
          q_nxt.tmr = 12'h000;
        end else if (ev_sel) begin
          q_nxt.st = ST_MENU;
          q_nxt.menu = 1'b0;
        end else if (tick && q_r.tmr == 12'(ALT_MS - 1)) begin
          q_nxt.tmr = 12'h000;
          case (q_r.alt)
            // latched flags keep a gone input on the display
            ALT_READ: q_nxt.alt = q_r.hi_lat ? ALT_HI : (q_r.lo_lat ? ALT_LO : ALT_READ);
            ALT_HI: q_nxt.alt = q_r.lo_lat ? ALT_LO : ALT_READ;
            default: q_nxt.alt = ALT_READ;
          endcase
        end
      end
      ST_MENU: begin
        if (ev_sel) begin
          q_nxt.st = ST_NORMAL;
        end else if (ev_up || ev_dn) begin
          q_nxt.menu = ~q_r.menu;
        end else if (ev_ent) begin
          q_nxt.st = ST_EDIT;
          q_nxt.idx = q_r.menu ? P_AEN : P_TYPE;
          q_nxt.pend = q_r.menu ? q_r.cfg[P_AEN] : q_r.cfg[P_TYPE];
          q_nxt.touched = 1'b0;
        end
      end
      ST_EDIT: begin
        if (ev_sel) begin
          // leave, pending value dropped, earlier commits kept
          q_nxt.st = ST_NORMAL;
        end else if (ev_up) begin
          q_nxt.touched = 1'b1;
          if (fpm_numeric(q_r.idx)) begin
            if (q_r.pend < fpm_max(q_r.idx)) q_nxt.pend = q_r.pend + 16'h0001;
          end else begin
            q_nxt.pend = (q_r.pend >= fpm_max(q_r.idx)) ? fpm_min(q_r.idx)
                                                         : q_r.pend + 16'h0001;
          end
        end else if (ev_dn) begin
          q_nxt.touched = 1'b1;
          if (fpm_numeric(q_r.idx)) begin
            if (q_r.pend != ZERO) q_nxt.pend = q_r.pend - 16'h0001;
          end else begin
            q_nxt.pend = (q_r.pend <= fpm_min(q_r.idx)) ? fpm_max(q_r.idx)
                                                         : q_r.pend - 16'h0001;
          end
        end else if (ev_ent) begin
          // commit only a touched value, then advance
          q_nxt.mem_we = q_r.touched;
          q_nxt.mem_a = q_r.idx;
          q_nxt.mem_wd = q_r.pend;
          q_nxt.cfg[q_r.idx] = q_r.pend;
          q_nxt.touched = 1'b0;
          q_nxt.idx = q_r.idx + 3'h1;
          q_nxt.pend = q_r.cfg[q_r.idx + 3'h1];
          if (q_r.idx == P_UNIT || q_r.idx == P_LATCH ||
              (q_r.idx == P_AEN && q_r.pend == ZERO)) begin
            q_nxt.st = ST_NORMAL;
            q_nxt.tmr = 12'h000;
          end
        end
      end
      ST_REV: begin
        if (tick && q_r.tmr == 12'(REV_MS - 1)) begin
          q_nxt.st = ST_NORMAL;
          q_nxt.tmr = 12'h000;
        end
      end
      default: q_nxt.st = ST_LOAD_A;
    endcase

    // alarm flags, latched only with latching on; set beats clear
    a_hi = alarm_hi_in & q_r.cfg[P_AEN][0];
    a_lo = alarm_lo_in & q_r.cfg[P_AEN][0];
    sw_clr = write & ~q_r.waitreq & (address == REG_CTRL) & writedata[CTRL_CLR_ALARM];
    if (q_r.cfg[P_LATCH][0]) begin
      q_nxt.hi_lat = (q_r.hi_lat & ~(ev_sel | sw_clr)) | a_hi;
      q_nxt.lo_lat = (q_r.lo_lat & ~(ev_sel | sw_clr)) | a_lo;
    end else begin
      q_nxt.hi_lat = a_hi;
      q_nxt.lo_lat = a_lo;
    end

    q_nxt.ditem = q_r.idx;
    q_nxt.dval = q_r.pend;
    q_nxt.led = 4'(1 << q_r.cfg[P_UNIT][1:0]);
    case (q_r.st)
      ST_NORMAL: begin
        if (q_r.alt == ALT_HI && q_r.hi_lat) q_nxt.dcode = DC_ALARM_HI;
        else if (q_r.alt == ALT_LO && q_r.lo_lat) q_nxt.dcode = DC_ALARM_LO;
        else if (q_r.cfg[P_TYPE] == TYPE_NONE) q_nxt.dcode = DC_STATUS;
        else q_nxt.dcode = DC_READING;
      end
      ST_MENU: begin
        q_nxt.dcode = DC_MENU;
        q_nxt.ditem = {2'h0, q_r.menu};
      end
      ST_EDIT: begin
        q_nxt.dcode = DC_PARAM;
        // unit LED follows the unit being chosen
        if (q_r.idx == P_UNIT) q_nxt.led = 4'(1 << q_r.pend[1:0]);
      end
      ST_REV: begin
        q_nxt.dcode = DC_REV;
        q_nxt.dval = REV_DATE;
      end
      default: begin
        q_nxt.dcode = DC_TEST;
        q_nxt.led = LED_ALL;
      end
    endcase

    // bus slave: one wait cycle, then answer
    if ((read || write) && q_r.waitreq) begin
      q_nxt.waitreq = 1'b0;
      if (address == REG_CTRL) q_nxt.rdata = 32'(q_r.sw_dis);
      else if (address == REG_STATUS)
        q_nxt.rdata = 32'({q_r.hi_lat, q_r.lo_lat, q_r.locked, q_r.st});
      else if (address == REG_DISPLAY) q_nxt.rdata = {8'h00, q_r.dcode, q_r.ditem,
        q_r.led[0], q_r.dval};
      else if (address == REG_SETUP) q_nxt.rdata = {q_r.cfg[P_UNIT], q_r.cfg[P_TYPE]};
      else q_nxt.rdata = 32'h0000_0000;
    end else begin
      q_nxt.waitreq = 1'b1;
    end
    if (write && !q_r.waitreq && address == REG_CTRL) begin
      q_nxt.sw_dis = writedata[CTRL_KEYS_OFF];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      q_r <= '0;
      q_r.st <= ST_LOAD_A;
      q_r.waitreq <= 1'b1;
      q_r.dcode <= DC_TEST;
      q_r.led <= LED_ALL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign readdata = q_r.rdata;
  assign waitrequest = q_r.waitreq;
  assign disp_code = q_r.dcode;
  assign disp_item = q_r.ditem;
  assign disp_value = q_r.dval;
  assign unit_led = q_r.led;
  assign keypad_locked = q_r.locked;
  assign hi_latched = q_r.hi_lat;
  assign lo_latched = q_r.lo_lat;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_test_entry;
    $rose(q_r.st == ST_TEST);
  endsequence
  sequence s_lamp_on;
    (q_r.dcode == DC_TEST) && (q_r.led == LED_ALL);
  endsequence

  property p_lamp;
    s_test_entry |=> s_lamp_on;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp test not shown");
  property p_boot_clear;
    $fell(srst) |-> !q_r.hi_lat && !q_r.lo_lat;
  endproperty
  a_boot_clear: assert property (p_boot_clear) else $error("alarm latch kept");
  property p_fill;
    q_r.st == ST_FILL |=> q_r.mem_we && q_r.mem_a == $past(q_r.idx)
      && q_r.mem_wd == DEFAULTS[$past(q_r.idx)];
  endproperty
  a_fill: assert property (p_fill) else $error("default not written");
  property p_status;
    (q_r.st == ST_NORMAL && q_r.cfg[P_TYPE] == TYPE_NONE && q_r.alt == ALT_READ)
      |=> q_r.dcode == DC_STATUS;
  endproperty
  a_status: assert property (p_status) else $error("status message missing");
  property p_led;
    q_r.st == ST_NORMAL |=> $onehot(q_r.led);
  endproperty
  a_led: assert property (p_led) else $error("unit LED not one-hot");
  property p_alarm_msg;
    (q_r.st == ST_NORMAL && q_r.alt == ALT_HI && q_r.hi_lat) |=> q_r.dcode == DC_ALARM_HI;
  endproperty
  a_alarm_msg: assert property (p_alarm_msg) else $error("high alarm not shown");
  property p_inc;
    (q_r.st == ST_EDIT && ev_up && !ev_sel && fpm_numeric(q_r.idx)
      && q_r.pend < fpm_max(q_r.idx)) |=> q_r.pend == $past(q_r.pend) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_cancel;
    (q_r.st == ST_EDIT && ev_sel) |=> q_r.st == ST_NORMAL && !q_r.mem_we;
  endproperty
  a_cancel: assert property (p_cancel) else $error("select did not cancel");
  property p_commit;
    (q_r.st == ST_EDIT && ev_ent && !ev_up && !ev_dn && !ev_sel && q_r.touched)
      |=> q_r.mem_we && q_r.mem_wd == $past(q_r.pend);
  endproperty
  a_commit: assert property (p_commit) else $error("enter did not store");
  property p_lock;
    ev_ent_long |=> q_r.locked != $past(q_r.locked);
  endproperty
  a_lock: assert property (p_lock) else $error("lock not toggled");
endmodule // fpm_panel

// ==== verification/fpm_operator.sv ====
/*
  operator at the front panel: presses and releases one key at a time.
  assumes key pins read high through pull-ups while released.
*/
`timescale 1ns/1ps
module fpm_operator (
  input wire logic clock,
  output logic [3:0] key_n
);
  // all keys released at start
  initial key_n = 4'hF;
  task automatic press(input int k, input int hold);
    @(posedge clock) key_n[k] <= 1'b0;
    repeat (hold) @(posedge clock);
    key_n[k] <= 1'b1;
    repeat (100) @(posedge clock);
  endtask
endmodule // fpm_operator

// ==== verification/testbench.sv ====
/*
  self-checking bench of the front panel control with a scaled millisecond.
  assumes the operator model and the package from core/.
*/
`timescale 1ns/1ps
module testbench;
  import fpm_pkg::*;
  localparam int CM = 2;
  localparam int SH = 100;
  localparam int LG = LONG_MS * CM + 300;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [3:0] key_n;
  logic alarm_hi_in = 1'b0;
  logic alarm_lo_in = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic [3:0] disp_code;
  logic [2:0] disp_item;
  logic [15:0] disp_value;
  logic [3:0] unit_led;
  logic keypad_locked;
  logic hi_latched;
  logic lo_latched;
  logic [31:0] rd;
  int bad_count = 0;
  int n_checks = 0;
  int e_type = 0;
  int n;
  int m;
  // clock of 10 ns
  always #5 clock = ~clock;
  fpm_operator fpm_operator_i (.clock(clock), .key_n(key_n));
  fpm_panel #(.CYC_MS(CM)) fpm_panel_i (.clock(clock), .srst(srst), .key_n(key_n),
    .alarm_hi_in(alarm_hi_in), .alarm_lo_in(alarm_lo_in), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .disp_code(disp_code), .disp_item(disp_item), .disp_value(disp_value),
    .unit_led(unit_led), .keypad_locked(keypad_locked), .hi_latched(hi_latched),
    .lo_latched(lo_latched));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
    output logic [31:0] d);
    int k = 0;
    @(posedge clock);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= wd;
    do @(posedge clock); while (waitrequest !== 1'b0 && ++k < 50);
    d = readdata;
    if (k >= 50) bad_count++;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic pk(input int k, input int hold);
    fpm_operator_i.press(k, hold);
  endtask
  // collect the display codes shown over four alternation steps
  task automatic watch(output int msk);
    msk = 0;
    repeat (40) begin
      repeat (200) @(posedge clock);
      msk = msk | (1 << disp_code);
    end
  endtask
  // watchdog
  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    finish_test;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(97));
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    check(disp_code, DC_TEST);
    check(unit_led, LED_ALL);
    repeat (TEST_MS * CM + 100) @(posedge clock);
    check(disp_code, DC_STATUS);
    bus(1'b0, REG_SETUP, 0, rd);
    check(rd, 0);
    pk(KEY_SEL, SH);
    check(disp_code, DC_MENU);
    pk(KEY_ENT, SH);
    check(disp_item, P_TYPE);
    pk(KEY_UP, SH);
    e_type = 1;
    n = $urandom % 8;
    for (int i = 0; i < n; i++) begin
      pk(KEY_UP, SH);
      e_type = e_type % 6 + 1;
    end
    check(disp_value, e_type);
    pk(KEY_DN, SH);
    e_type = (e_type == 1) ? 6 : e_type - 1;
    check(disp_value, e_type);
    pk(KEY_ENT, SH);
    check(disp_item, P_UNIT);
    pk(KEY_UP, SH);
    pk(KEY_ENT, SH);
    check(disp_code, DC_READING);
    check(unit_led, 4'h2);
    // skip the type, then cancel a unit change
    pk(KEY_SEL, SH);
    pk(KEY_ENT, SH);
    pk(KEY_ENT, SH);
    pk(KEY_UP, SH);
    pk(KEY_SEL, SH);
    check(disp_code, DC_READING);
    bus(1'b0, REG_SETUP, 0, rd);
    check(rd, 32'(65536 + e_type));
    pk(KEY_SEL, LG);
    check(disp_code, DC_REV);
    check(disp_value, REV_DATE);
    repeat (REV_MS * CM) @(posedge clock);
    pk(KEY_ENT, LG);
    check(keypad_locked, 1);
    pk(KEY_SEL, SH);
    check(disp_code, DC_READING);
    pk(KEY_ENT, LG);
    check(keypad_locked, 0);
    // keys disabled from the bus
    bus(1'b1, REG_CTRL, 1, rd);
    bus(1'b0, REG_CTRL, 0, rd);
    check(rd, 1);
    pk(KEY_SEL, SH);
    check(disp_code, DC_READING);
    bus(1'b1, REG_CTRL, 0, rd);
    // alarm setup with a held arrow, latching on
    pk(KEY_SEL, SH);
    pk(KEY_UP, SH);
    check(disp_item, 1);
    pk(KEY_ENT, SH);
    pk(KEY_UP, SH);
    pk(KEY_ENT, SH);
    pk(KEY_UP, (HOLD_MS + 20 * FAST_MS) * CM);
    check(32'(disp_value > 16'h000A), 1);
    repeat (3) pk(KEY_ENT, SH);
    pk(KEY_UP, SH);
    pk(KEY_ENT, SH);
    alarm_hi_in <= 1'b1;
    watch(m);
    check(m, (1 << DC_READING) | (1 << DC_ALARM_HI));
    alarm_hi_in <= 1'b0;
    alarm_lo_in <= 1'b1;
    @(posedge clock);
    alarm_lo_in <= 1'b0;
    watch(m);
    check(m, (1 << DC_READING) | (1 << DC_ALARM_HI) | (1 << DC_ALARM_LO));
    check({hi_latched, lo_latched}, 2'b11);
    // clear latches from the bus, then latch a low alarm again
    bus(1'b1, REG_CTRL, 32'h0000_0002, rd);
    @(posedge clock);
    check({hi_latched, lo_latched}, 2'b00);
    alarm_lo_in <= 1'b1;
    @(posedge clock);
    alarm_lo_in <= 1'b0;
    bus(1'b0, REG_STATUS, 0, rd);
    check(rd, 32'({2'b01, 1'b0, ST_NORMAL}));
    bus(1'b1, 4'h6, 32'hFFFF_FFFF, rd);
    bus(1'b0, 4'h2, 0, rd);
    check(rd, 0);
    srst <= 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    check({hi_latched, lo_latched}, 2'b00);
    repeat (TEST_MS * CM + 100) @(posedge clock);
    check(disp_code, DC_READING);
    bus(1'b0, REG_SETUP, 0, rd);
    check(rd, 32'(65536 + e_type));
    finish_test;
  end
endmodule // testbench
